// ==== shared/cle_pkg.sv ====
// Package of constants and types for the character display instruction engine
package cle_pkg;
  // Execution times as printed, and the clock rate
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam real T_LONG_US = 1530.0;
  localparam real T_CMD_US = 39.0;
  localparam real T_DATA_US = 43.0;
  localparam real T_HALF_OSC_US = 1.0e6 / 270_000.0 / 2.0;
  // Least times round up to whole cycles
  localparam int unsigned CYC_LONG =
    int'($ceil(T_LONG_US * CLK_HZ / 1.0e6));
  localparam int unsigned CYC_CMD = int'($ceil(T_CMD_US * CLK_HZ / 1.0e6));
  localparam int unsigned CYC_DATA =
    int'($ceil(T_DATA_US * CLK_HZ / 1.0e6));
  localparam int unsigned CYC_HALF =
    int'($ceil(T_HALF_OSC_US * CLK_HZ / 1.0e6));
  localparam int CNT_W = 18;
  // Address layout
  localparam logic [6:0] ADDR_ZERO = 7'h00;
  localparam logic [6:0] ADDR_ONE = 7'h01;
  localparam logic [6:0] ROW0_LAST = 7'h27;
  localparam logic [6:0] ROW1_FIRST = 7'h40;
  localparam logic [6:0] ROW1_LAST = 7'h67;
  localparam logic [6:0] ONE_ROW_LAST = 7'h4F;
  localparam logic [5:0] GLYPH_MASK = 6'h3F;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] FLASH_DOTS = 8'hFF;
  localparam int CHAR_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam logic [5:0] SHIFT_LAST = 6'd39;
  localparam int FLASH_W = 24;

  // Engine states, Gray coded along the usual path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_CLEAR = 2'b11
  } cle_state_e;

  // Latched settings of the display
  typedef struct packed {
    logic step_up;
    logic auto_scroll;
    logic panel_on;
    logic mark_on;
    logic mark_flash;
    logic bus_width_sel;
    logic two_rows;
    logic tall_glyph;
  } cle_cfg_s;
endpackage

// ==== src/cle_engine.sv ====
// Instruction interpreter of a character display controller
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Clear: fill char RAM with spaces, address zero, step up.
// R2 - Home: address zero, undo display shift, RAM kept.
// R3 - Clear and home keep busy about 1.53 ms.
// R4 - Entry mode latches step direction and auto-scroll; 39 us.
// R5 - Each access steps address up or down by the step direction.
// R6 - Glyph RAM accesses step the address the same way.
// R7 - Display shifts only on char RAM write with auto-scroll high.
// R8 - Display control latches panel visible; off blanks, RAM kept.
// R9 - Mark visible shows cursor; off hides it, direction kept. The engine only latches mark_on and never draws a cursor from it.
// R10 - Mark flash alternates cursor cell between all dots and character.
// R11 - Shift code moves cursor or display, no RAM change; 39 us.
// R12 - Two rows: past position 40 of row one goes to row two.
// R13 - Display shift moves all rows together, each in its own row.
// R14 - Display shift leaves the address counter unchanged.
// R15 - Function set latches width, rows and glyph height; 39 us.
// R16 - Glyph address code loads six bits, selects glyph RAM; 39 us.
// R17 - Char address code loads seven bits, selects char RAM; 39 us.
// R18 - Status read returns busy on bit 7, address below, anytime.
// R19 - Busy high during any operation; host waits for low.
// R20 - Data write stores at address, then steps; 43 us.
// R21 - Data read returns the byte latched by the previous read, relatches the byte at address, then steps; 43 us.
// R22 - Host waits half an oscillator period after busy low.
// R23 - Width low: upper four lines, two transfers per byte.
// R24 - Two rows: row one 0x00-0x27, row two 0x40-0x67.
// R25 - Cursor shift steps address; display shift moves, cursor follows.
// R26 - Four-bit mode: upper nibble first, then lower, both ways.
module cle_engine (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // Host bus, one strobe pulse per transfer
  input wire logic STB_I,
  input wire logic REG_SELECT_I,
  input wire logic READ_I,
  input wire logic [7:0] BUS_LINES_I,
  output logic [7:0] BUS_LINES_O,
  output logic [7:0] BUS_LINES_OE_O,
  // Display side
  input wire logic [6:0] SCAN_ADDR_I,
  output logic [7:0] SCAN_DATA_O,
  output logic [5:0] SHIFT_POS_O,
  output var cle_pkg::cle_cfg_s CFG_O,
  output logic BUSY_O
);
  import cle_pkg::*;

  // Step an address per direction, keeping char RAM rows legal
  function automatic logic [6:0] step_addr(input logic [6:0] a,
      input logic up, input logic glyph, input logic rows2);
    logic [6:0] r;
    r = up ? a + ADDR_ONE : a - ADDR_ONE;
    if (glyph) begin
      r = r & {1'b0, GLYPH_MASK}; // R6
    end else if (rows2) begin
      if (up && a == ROW0_LAST) r = ROW1_FIRST; // R12 R24
      else if (up && a == ROW1_LAST) r = ADDR_ZERO;
      else if (!up && a == ROW1_FIRST) r = ROW0_LAST;
      else if (!up && a == ADDR_ZERO) r = ROW1_LAST;
    end else begin
      if (up && a == ONE_ROW_LAST) r = ADDR_ZERO;
      else if (!up && a == ADDR_ZERO) r = ONE_ROW_LAST;
    end
    return r;
  endfunction

  // Display shift position wraps within one 40-cell row
  function automatic logic [5:0] step_shift(input logic [5:0] s,
      input logic left);
    if (left) return (s == SHIFT_LAST) ? 6'h00 : s + 6'h01;
    return (s == 6'h00) ? SHIFT_LAST : s - 6'h01;
  endfunction

  logic [7:0] char_mem [CHAR_DEPTH];
  logic [7:0] glyph_mem [GLYPH_DEPTH];

  cle_state_e state, next_state;
  cle_cfg_s cfg, next_cfg;
  logic [6:0] addr_counter, next_addr_counter;
  logic glyph_sel, next_glyph_sel;
  logic [5:0] shift_pos, next_shift_pos;
  logic [CNT_W-1:0] wait_cnt, next_wait_cnt;
  logic nib_phase, next_nib_phase;
  logic [3:0] nib_hi, next_nib_hi;
  logic [7:0] rd_byte, next_rd_byte;
  logic [7:0] bus_out, next_bus_out;
  logic [7:0] bus_oe, next_bus_oe;
  logic [6:0] clr_addr, next_clr_addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic [6:0] wr_addr;
  logic wr_glyph;
  logic [FLASH_W-1:0] flash_cnt;
  logic [7:0] scan_data;

  // Byte assembly: full byte, or two nibbles upper first
  logic byte_done;
  logic [7:0] in_byte;
  logic busy;
  assign busy = (state != ST_IDLE);

  always_comb begin
    logic [7:0] status;
    logic [7:0] ram_now;
    logic [7:0] src;
    status = {busy, addr_counter}; // R18
    src = status;
    ram_now = glyph_sel ? glyph_mem[addr_counter[5:0]]
                        : char_mem[addr_counter];
    next_state = state;
    next_cfg = cfg;
    next_addr_counter = addr_counter;
    next_glyph_sel = glyph_sel;
    next_shift_pos = shift_pos;
    next_wait_cnt = wait_cnt;
    next_nib_phase = nib_phase;
    next_nib_hi = nib_hi;
    next_rd_byte = rd_byte;
    next_bus_out = bus_out;
    next_bus_oe = bus_oe;
    next_clr_addr = clr_addr;
    wr_en = 1'b0;
    wr_data = SPACE_CODE;
    wr_addr = addr_counter;
    wr_glyph = glyph_sel;
    byte_done = 1'b0;
    in_byte = BUS_LINES_I;
    if (STB_I) begin
      if (cfg.bus_width_sel) begin
        byte_done = 1'b1; // R23
      end else if (!nib_phase) begin
        next_nib_hi = BUS_LINES_I[7:4]; // R26
        next_nib_phase = 1'b1;
      end else begin
        in_byte = {nib_hi, BUS_LINES_I[7:4]}; // R26
        byte_done = 1'b1;
        next_nib_phase = 1'b0;
      end
      // Reads drive bus: status anytime, data from the read latch
      if (READ_I) begin
        src = REG_SELECT_I ? rd_byte : status; // R18 R21
        if (cfg.bus_width_sel) next_bus_out = src;
        else if (!nib_phase) next_bus_out = {src[7:4], 4'h0}; // R26
        else next_bus_out = {src[3:0], 4'h0};
        next_bus_oe = cfg.bus_width_sel ? 8'hFF : 8'hF0; // R23
      end else begin
        next_bus_oe = 8'h00;
      end
    end
    // Instructions during busy are ignored by the engine
    if (byte_done && state == ST_IDLE) begin
      if (REG_SELECT_I && !READ_I) begin
        wr_en = 1'b1; // R20
        wr_data = in_byte;
        next_addr_counter = step_addr(addr_counter, cfg.step_up,
            glyph_sel, cfg.two_rows); // R5 R6
        if (!glyph_sel && cfg.auto_scroll) begin
          next_shift_pos = step_shift(shift_pos, cfg.step_up); // R7
        end
        next_wait_cnt = CNT_W'(CYC_DATA);
        next_state = ST_EXEC;
      end else if (REG_SELECT_I && READ_I) begin
        // Latch holds byte at the address, stepped after use
        next_rd_byte = ram_now; // R21
        next_addr_counter = step_addr(addr_counter, cfg.step_up,
            glyph_sel, cfg.two_rows);
        next_wait_cnt = CNT_W'(CYC_DATA);
        next_state = ST_EXEC;
      end else if (!READ_I) begin
        next_wait_cnt = CNT_W'(CYC_CMD);
        next_state = ST_EXEC;
        if (in_byte[7]) begin
          next_addr_counter = in_byte[6:0]; // R17
          next_glyph_sel = 1'b0;
        end else if (in_byte[6]) begin
          next_addr_counter = {1'b0, in_byte[5:0]}; // R16
          next_glyph_sel = 1'b1;
        end else if (in_byte[5]) begin
          next_cfg.bus_width_sel = in_byte[4]; // R15
          next_cfg.two_rows = in_byte[3];
          next_cfg.tall_glyph = in_byte[2];
        end else if (in_byte[4]) begin
          if (in_byte[3]) begin
            next_shift_pos = step_shift(shift_pos, !in_byte[2]); // R13 R14
          end else begin
            next_addr_counter = step_addr(addr_counter, in_byte[2],
                1'b0, cfg.two_rows); // R11 R25
            next_glyph_sel = 1'b0;
          end
        end else if (in_byte[3]) begin
          next_cfg.panel_on = in_byte[2]; // R8
          next_cfg.mark_on = in_byte[1]; // R9
          next_cfg.mark_flash = in_byte[0]; // R10
        end else if (in_byte[2]) begin
          next_cfg.step_up = in_byte[1]; // R4
          next_cfg.auto_scroll = in_byte[0];
        end else if (in_byte[1]) begin
          next_addr_counter = ADDR_ZERO; // R2
          next_shift_pos = 6'h00;
          next_glyph_sel = 1'b0;
          next_wait_cnt = CNT_W'(CYC_LONG); // R3
        end else if (in_byte[0]) begin
          next_addr_counter = ADDR_ZERO; // R1
          next_shift_pos = 6'h00;
          next_glyph_sel = 1'b0;
          next_cfg.step_up = 1'b1;
          next_clr_addr = ADDR_ZERO;
          next_wait_cnt = CNT_W'(CYC_LONG); // R3
          next_state = ST_CLEAR;
        end else begin
          next_state = ST_IDLE;
        end
      end
    end else if (state != ST_IDLE) begin
      // Busy until the execution count runs out
      next_wait_cnt = wait_cnt - CNT_W'(1); // R19
      if (state == ST_CLEAR) begin
        wr_en = 1'b1; // R1
        wr_glyph = 1'b0;
        wr_addr = clr_addr;
        wr_data = SPACE_CODE;
        next_clr_addr = clr_addr + ADDR_ONE;
      end
      if (wait_cnt <= CNT_W'(1)) next_state = ST_IDLE;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      cfg <= '{step_up: 1'b1, bus_width_sel: 1'b1, default: 1'b0};
      addr_counter <= ADDR_ZERO;
      glyph_sel <= 1'b0;
      shift_pos <= 6'h00;
      wait_cnt <= '0;
      nib_phase <= 1'b0;
      nib_hi <= 4'h0;
      rd_byte <= 8'h00;
      bus_out <= 8'h00;
      bus_oe <= 8'h00;
      clr_addr <= ADDR_ZERO;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      addr_counter <= next_addr_counter;
      glyph_sel <= next_glyph_sel;
      shift_pos <= next_shift_pos;
      wait_cnt <= next_wait_cnt;
      nib_phase <= next_nib_phase;
      nib_hi <= next_nib_hi;
      rd_byte <= next_rd_byte;
      bus_out <= next_bus_out;
      bus_oe <= next_bus_oe;
      clr_addr <= next_clr_addr;
    end
  end

  // RAM write port; arrays hold no reset so they map to memory
  always_ff @(posedge MCLK_I) begin
    if (wr_en && wr_glyph) glyph_mem[wr_addr[5:0]] <= wr_data;
    if (wr_en && !wr_glyph) char_mem[wr_addr] <= wr_data;
  end

  // Panel view: blanking and the flashing cursor cell
  always_comb begin
    scan_data = char_mem[SCAN_ADDR_I];
    if (cfg.mark_flash && flash_cnt[FLASH_W-1] &&
        SCAN_ADDR_I == addr_counter && !glyph_sel) begin
      scan_data = FLASH_DOTS; // R10
    end
    if (!cfg.panel_on) scan_data = SPACE_CODE; // R8
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      flash_cnt <= '0;
      SCAN_DATA_O <= 8'h00;
      SHIFT_POS_O <= 6'h00;
      CFG_O <= '0;
      BUSY_O <= 1'b0;
    end else begin
      flash_cnt <= flash_cnt + FLASH_W'(1);
      SCAN_DATA_O <= scan_data;
      SHIFT_POS_O <= shift_pos;
      CFG_O <= cfg;
      BUSY_O <= busy; // R19
    end
  end

  assign BUS_LINES_O = bus_out;
  assign BUS_LINES_OE_O = bus_oe;

  // Checks
  // Plain flag rather than a sequence, so properties may combine it freely
  logic cmd_taken;
  assign cmd_taken = STB_I && byte_done && !REG_SELECT_I && !READ_I &&
      state == ST_IDLE;
  busy_after_cmd_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte != 8'h00 |=> busy) // R19
    else $error("busy not raised after instruction");
  clear_home_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte[7:1] == 7'h00 && in_byte[0] |=>
    addr_counter == ADDR_ZERO && cfg.step_up) // R1
    else $error("clear did not zero address");
  home_addr_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte[7:2] == 6'h00 && in_byte[1] |=>
    addr_counter == ADDR_ZERO && shift_pos == 6'h00) // R2
    else $error("home did not reset position");
  entry_latch_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte[7:3] == 5'h00 && in_byte[2] |=>
    cfg.step_up == $past(in_byte[1])) // R4
    else $error("entry mode not latched");
  disp_shift_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte[7:4] == 4'h1 && in_byte[3] |=>
    $stable(addr_counter)) // R14
    else $error("display shift moved address");
  char_ram_set_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte[7] |=>
    addr_counter == $past(in_byte[6:0]) && !glyph_sel) // R17
    else $error("char address not loaded");
  glyph_ram_set_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte[7:6] == 2'b01 |=> glyph_sel) // R16
    else $error("glyph select not set");
  status_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    STB_I && READ_I && !REG_SELECT_I && cfg.bus_width_sel |=>
    bus_out == {$past(busy), $past(addr_counter)}) // R18
    else $error("status read wrong");
  cmd_time_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cmd_taken && in_byte[7] |=> busy [*8]) // R17
    else $error("command busy too short");
endmodule
`default_nettype wire

// ==== tb/cle_host.sv ====
// Host processor model driving the engine's strobed bus
`timescale 1ns/1ps
`default_nettype none
module cle_host (
  // Clock
  input wire logic clk_i,
  // Bus towards the engine
  output logic stb_o,
  output logic rs_o,
  output logic rd_o,
  output logic [7:0] d_o,
  input wire logic [7:0] d_i
);
  import cle_pkg::*;
  logic nib = 1'b0; // High in four-bit mode
  // Quiet bus at time zero
  initial begin
    stb_o = 1'b0;
    rs_o = 1'b0;
    rd_o = 1'b0;
    d_o = 8'h00;
  end
  // One strobe; released data lines show the inverse, never a stale value
  task automatic put(input logic rs, input logic rd, input logic [7:0] b,
    output logic [7:0] q);
    @(negedge clk_i);
    stb_o = 1'b1;
    rs_o = rs;
    rd_o = rd;
    d_o = b;
    @(negedge clk_i);
    stb_o = 1'b0;
    d_o = ~b;
    @(negedge clk_i);
    q = d_i;
  endtask
  // A whole byte; two nibbles, upper first, on the narrow bus
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] b,
    output logic [7:0] q);
    logic [7:0] u;
    logic [7:0] l;
    if (nib) begin
      put(rs, rd, {b[7:4], 4'h0}, u);
      put(rs, rd, {b[3:0], 4'h0}, l);
      q = {u[7:4], l[7:4]};
    end else begin
      put(rs, rd, b, q);
    end
  endtask
  // Poll busy until low, then keep the half oscillator period gap
  task automatic idle;
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h80;
    while (s[7] !== 1'b0 && n < 70000) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      n++;
    end
    repeat (CYC_HALF) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the display instruction engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cle_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stb, rs, rd, busy;
  logic [7:0] di, dout, oe, sd, q, d, a, g, x;
  logic [7:0] lf = 8'h3C;
  logic [7:0] ls = 8'h3C;
  logic [6:0] scan = 7'h00;
  logic [5:0] sp, sp0;
  cle_cfg_s cfg;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  cle_host h (.clk_i(clk), .stb_o(stb), .rs_o(rs), .rd_o(rd), .d_o(di),
    .d_i(dout));
  cle_engine DUT (.MCLK_I(clk), .RST_I(rst), .STB_I(stb),
    .REG_SELECT_I(rs), .READ_I(rd), .BUS_LINES_I(di), .BUS_LINES_O(dout),
    .BUS_LINES_OE_O(oe), .SCAN_ADDR_I(scan), .SCAN_DATA_O(sd),
    .SHIFT_POS_O(sp), .CFG_O(cfg), .BUSY_O(busy));
  // Eight-bit shift register for repeatable values
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Panel scan address wanders at random
  always @(negedge clk) begin
    ls <= nx(ls);
    scan <= ls[6:0];
  end
  // Verdict and end of run
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 200000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Instruction or data access once the engine is free
  task automatic op(input logic r, input logic w, input logic [7:0] b);
    h.idle();
    h.xfer(r, w, b, q);
  endtask
  // Status read compared with the expected address counter
  task automatic ac(input logic [6:0] e);
    h.idle();
    h.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, {1'b0, e}, "status");
  endtask
  // Busy pulse length; loose by a few cycles of pipeline
  task automatic bcnt(input int e);
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (busy === 1'b1 && n < 200000) begin
      @(negedge clk);
      n++;
    end
    chk(n >= e - 4 && n <= e, 1, "busy length");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Two rows, eight-bit bus, short glyphs
    op(1'b0, 1'b0, 8'h38);
    bcnt(CYC_CMD);
    ac(7'h00);
    chk(cfg[2:0], 3'b110, "function set");
    chk(oe, 8'hFF, "drive");
    $display("done: function set");
    // Write, then read back through the stale first read
    lf = nx(lf);
    a = lf % 8'h25;
    lf = nx(lf);
    d = lf;
    op(1'b0, 1'b0, {1'b1, a[6:0]});
    ac(a[6:0]);
    op(1'b1, 1'b0, d);
    bcnt(CYC_DATA);
    ac(a[6:0] + 7'h01);
    op(1'b0, 1'b0, {1'b1, a[6:0]});
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    chk(q, d, "read data");
    h.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q[7], 1'b1, "busy bit");
    ac(a[6:0] + 7'h02);
    $display("done: ram access");
    // Step down with auto-scroll, then a display shift
    op(1'b0, 1'b0, 8'h05);
    sp0 = sp;
    op(1'b1, 1'b0, d);
    ac(a[6:0] + 7'h01);
    chk(cfg[7:6], 2'b01, "entry mode");
    chk(sp !== sp0, 1'b1, "scroll");
    sp0 = sp;
    op(1'b0, 1'b0, 8'h1C);
    ac(a[6:0] + 7'h01);
    chk(sp !== sp0, 1'b1, "display shift");
    // Glyph RAM write steps down and never scrolls
    lf = nx(lf);
    g = {2'b01, lf[5:1], 1'b1};
    sp0 = sp;
    op(1'b0, 1'b0, g);
    op(1'b1, 1'b0, d);
    ac({1'b0, g[5:0]} - 7'h01);
    chk(sp, sp0, "glyph scroll");
    $display("done: scrolling");
    // Cursor shifts across the row boundary
    op(1'b0, 1'b0, 8'hA7);
    op(1'b0, 1'b0, 8'h10);
    ac(7'h26);
    op(1'b0, 1'b0, 8'h14);
    op(1'b0, 1'b0, 8'h14);
    ac(7'h40);
    // Panel off blanks the scan data
    lf = nx(lf);
    op(1'b0, 1'b0, {6'b000010, lf[0], 1'b0});
    ac(7'h40);
    chk(cfg[5:3], {1'b0, lf[0], 1'b0}, "display control");
    chk(sd, SPACE_CODE, "blank");
    // An instruction sent while busy is dropped
    x = {3'b000, lf[4:1], 1'b1};
    op(1'b0, 1'b0, {1'b1, x[6:0]});
    h.xfer(1'b0, 1'b0, 8'hE0, q);
    ac(x[6:0]);
    $display("done: cursor and control");
    // Four-bit bus, nibbles upper first both ways
    op(1'b0, 1'b0, 8'h28);
    h.nib = 1'b1;
    ac(x[6:0]);
    chk(oe, 8'hF0, "nibble drive");
    chk(cfg[2], 1'b0, "width");
    op(1'b1, 1'b0, d);
    ac(x[6:0] - 7'h01);
    $display("done: four-bit bus");
    finish_test();
  end
endmodule
`default_nettype wire
